// *** core/orx_map.svh ***
// Purpose: Constants for the OR / move / pointer-load execution slice
// Assumes: 16-bit program words, 8-bit data, 4096-byte data space
// Notes:   Offsets are indices on the plain register port
// Summary of operation
// RULE_01 - Literal OR: accumulator gets accumulator OR 8-bit literal.
// RULE_02 - Register OR: accumulator ORed with the addressed file register.
// RULE_03 - Destination bit clear sends the result to the accumulator.
// RULE_04 - Destination bit set writes the result back to the file register.
// RULE_05 - Bank bit clear selects the fixed access bank.
// RULE_06 - Bank bit set takes upper address bits from the bank pointer.
// RULE_07 - Bank bit clear, extended set on, address up to 95: indexed offset.
// RULE_08 - OR and move instructions update only negative and zero flags.
// RULE_09 - Pointer load puts a 12-bit literal into pointer 0 to 2.
// RULE_10 - Register move copies the file register to the chosen destination.
// RULE_11 - Move address reaches any location of the selected 256-byte bank.
// RULE_12 - Pointer load: two words, high part first cycle, low byte second.
// RULE_13 - OR and move take one cycle: decode, read, process, write.
`ifndef ORX_MAP_SVH
`define ORX_MAP_SVH

`define ORX_OP_OR_LIT     8'h09
`define ORX_OP_OR_FILE    6'h04
`define ORX_OP_MOVE_FILE  6'h14
`define ORX_OP_PTR_FIRST  10'h3b8
`define ORX_OP_PTR_SECOND 8'hf0
`define ORX_PTR_SEL_BAD   2'h3
`define ORX_ILO_MAX       8'h5f
`define ORX_ACC_LO_BANK   4'h0
`define ORX_ACC_HI_BANK   4'hf

`define ORX_BIT_DEST      9
`define ORX_BIT_BANK      8
`define ORX_FLAG_Z        0
`define ORX_FLAG_N        1

`define ORX_REG_ACC       4'h0
`define ORX_REG_BANK      4'h1
`define ORX_REG_FLAGS     4'h2
`define ORX_REG_PTR0      4'h3
`define ORX_REG_PTR1      4'h4
`define ORX_REG_PTR2      4'h5
`define ORX_REG_CFG       4'h6
`define ORX_REG_MADDR     4'h7
`define ORX_REG_MDATA     4'h8

`define ORX_RST_ACC       8'h00
`define ORX_RST_BANK      4'h0
`define ORX_RST_PTR       12'h000
`define ORX_RST_FLAGS     2'h0

`endif

// *** core/orx_pkg.sv ***
// Purpose: Types for the execution slice
// Assumes: Constants come from orx_map.svh
// Notes:   No timescale in a package
package orx_pkg;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } orx_instr_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } orx_rbus_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4
  } orx_state_t;

  typedef enum logic [2:0] {
    CL_NOP, CL_OR_LIT, CL_OR_FILE, CL_MOVE, CL_PTR_HI, CL_PTR_LO
  } orx_class_t;

endpackage

// *** core/orx_exec.sv ***
// Purpose: Executes literal OR, register OR, register move and pointer load
// Assumes: One instruction word taken while idle; four quarter phases each
// Notes:   Data memory is modelled here; software reaches it via MADDR/MDATA
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "orx_map.svh"

module orx_exec (
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  input  wire orx_pkg::orx_instr_t instr_i,
  input  wire orx_pkg::orx_rbus_t  rbus_i,
  output logic [15:0]              rd_data_o,
  output logic                     busy_o,
  output logic [7:0]               acc_o,
  output logic [1:0]               flags_o
);

  orx_pkg::orx_state_t state_reg;
  orx_pkg::orx_state_t state_next;
  orx_pkg::orx_class_t cls_reg;
  orx_pkg::orx_class_t cls_next;
  logic [15:0]         instr_reg;
  logic [11:0]         addr_reg;
  logic [11:0]         addr_next;
  logic                dest_reg;
  logic [7:0]          opnd_reg;
  logic [7:0]          result_reg;
  logic [7:0]          acc_reg;
  logic [3:0]          bank_reg;
  logic [11:0]         ptr_reg [0:2];
  logic [1:0]          flags_reg;
  logic                ext_en_reg;
  logic [11:0]         maddr_reg;
  logic                ptr_pend_reg;
  logic [1:0]          ptr_sel_reg;
  logic [7:0]          mem [0:4095];
  logic                take;
  logic                q4_file;
  logic [7:0]          fa;

  assign take    = (state_reg == orx_pkg::ST_IDLE) && instr_i.valid;
  assign fa      = instr_reg[7:0];
  assign q4_file = (state_reg == orx_pkg::ST_Q4)
                   && (cls_reg == orx_pkg::CL_OR_FILE || cls_reg == orx_pkg::CL_MOVE);
  assign acc_o   = acc_reg;
  assign flags_o = flags_reg;

  // Quarter phase sequencer
  always_comb
  begin
    case (state_reg)
      orx_pkg::ST_IDLE: state_next = take ? orx_pkg::ST_Q1 : orx_pkg::ST_IDLE;
      orx_pkg::ST_Q1:   state_next = orx_pkg::ST_Q2; // RULE_13
      orx_pkg::ST_Q2:   state_next = orx_pkg::ST_Q3;
      orx_pkg::ST_Q3:   state_next = orx_pkg::ST_Q4;
      default:          state_next = orx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_reg <= orx_pkg::ST_IDLE;
      busy_o    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      busy_o    <= (state_next != orx_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      instr_reg <= 16'h0000;
    else if (take)
      instr_reg <= instr_i.word;
  end

  // Decode; a selector of 3 or an unknown word runs as a no-operation
  always_comb
  begin
    cls_next = orx_pkg::CL_NOP;
    if (instr_reg[15:8] == `ORX_OP_OR_LIT)
      cls_next = orx_pkg::CL_OR_LIT; // RULE_01
    else if (instr_reg[15:10] == `ORX_OP_OR_FILE)
      cls_next = orx_pkg::CL_OR_FILE; // RULE_02
    else if (instr_reg[15:10] == `ORX_OP_MOVE_FILE)
      cls_next = orx_pkg::CL_MOVE; // RULE_10
    else if (instr_reg[15:6] == `ORX_OP_PTR_FIRST && instr_reg[5:4] != `ORX_PTR_SEL_BAD)
      cls_next = orx_pkg::CL_PTR_HI; // RULE_09
    else if (ptr_pend_reg && instr_reg[15:8] == `ORX_OP_PTR_SECOND)
      cls_next = orx_pkg::CL_PTR_LO; // RULE_12
  end

  // Effective file address
  always_comb
  begin
    if (instr_reg[`ORX_BIT_BANK])
      addr_next = {bank_reg, fa}; // RULE_06 RULE_11
    else if (ext_en_reg && fa <= `ORX_ILO_MAX)
      addr_next = ptr_reg[2] + {4'h0, fa}; // RULE_07
    else if (fa[7])
      addr_next = {`ORX_ACC_HI_BANK, fa}; // RULE_05
    else
      addr_next = {`ORX_ACC_LO_BANK, fa};
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      cls_reg  <= orx_pkg::CL_NOP;
      addr_reg <= 12'h000;
      dest_reg <= 1'b0;
    end
    else if (state_reg == orx_pkg::ST_Q1)
    begin
      cls_reg  <= cls_next;
      addr_reg <= addr_next;
      dest_reg <= instr_reg[`ORX_BIT_DEST];
    end
  end

  // Read operand in Q2, process in Q3
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      opnd_reg <= 8'h00;
    else if (state_reg == orx_pkg::ST_Q2)
    begin
      if (cls_reg == orx_pkg::CL_OR_FILE || cls_reg == orx_pkg::CL_MOVE)
        opnd_reg <= mem[addr_reg];
      else
        opnd_reg <= instr_reg[7:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      result_reg <= 8'h00;
    else if (state_reg == orx_pkg::ST_Q3)
    begin
      if (cls_reg == orx_pkg::CL_MOVE)
        result_reg <= opnd_reg; // RULE_10
      else
        result_reg <= acc_reg | opnd_reg; // RULE_01 RULE_02
    end
  end

  // Accumulator: the instruction wins over a software write in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      acc_reg <= `ORX_RST_ACC;
    else if (state_reg == orx_pkg::ST_Q4 && (cls_reg == orx_pkg::CL_OR_LIT || (q4_file && !dest_reg)))
      acc_reg <= result_reg; // RULE_01 RULE_03
    else if (rbus_i.wr && rbus_i.addr == `ORX_REG_ACC)
      acc_reg <= rbus_i.wdata[7:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      flags_reg <= `ORX_RST_FLAGS;
    else if (state_reg == orx_pkg::ST_Q4
             && (cls_reg == orx_pkg::CL_OR_LIT || q4_file))
    begin
      flags_reg[`ORX_FLAG_N] <= result_reg[7]; // RULE_08
      flags_reg[`ORX_FLAG_Z] <= (result_reg == 8'h00);
    end
    else if (rbus_i.wr && rbus_i.addr == `ORX_REG_FLAGS)
      flags_reg <= rbus_i.wdata[1:0];
  end

  // Data memory holds no reset; it is data, not control
  always_ff @(posedge mclk_i)
  begin
    if (q4_file && dest_reg)
      mem[addr_reg] <= result_reg; // RULE_04
    else if (rbus_i.wr && rbus_i.addr == `ORX_REG_MDATA)
      mem[maddr_reg] <= rbus_i.wdata[7:0];
  end

  // Pointer load: high nibble on the first word, low byte on the second
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ptr_pend_reg <= 1'b0;
      ptr_sel_reg  <= 2'h0;
    end
    else if (state_reg == orx_pkg::ST_Q4)
    begin
      // Any other word between the two halves drops the pairing
      ptr_pend_reg <= (cls_reg == orx_pkg::CL_PTR_HI); // RULE_12
      if (cls_reg == orx_pkg::CL_PTR_HI)
        ptr_sel_reg <= instr_reg[5:4];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < 3; i++)
        ptr_reg[i] <= `ORX_RST_PTR;
    end
    else if (state_reg == orx_pkg::ST_Q4 && cls_reg == orx_pkg::CL_PTR_HI)
      ptr_reg[instr_reg[5:4]][11:8] <= instr_reg[3:0]; // RULE_09 RULE_12
    else if (state_reg == orx_pkg::ST_Q4 && cls_reg == orx_pkg::CL_PTR_LO)
      ptr_reg[ptr_sel_reg][7:0] <= instr_reg[7:0]; // RULE_12
    else if (rbus_i.wr && rbus_i.addr == `ORX_REG_PTR0)
      ptr_reg[0] <= rbus_i.wdata[11:0];
    else if (rbus_i.wr && rbus_i.addr == `ORX_REG_PTR1)
      ptr_reg[1] <= rbus_i.wdata[11:0];
    else if (rbus_i.wr && rbus_i.addr == `ORX_REG_PTR2)
      ptr_reg[2] <= rbus_i.wdata[11:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      bank_reg   <= `ORX_RST_BANK;
      ext_en_reg <= 1'b0;
      maddr_reg  <= 12'h000;
    end
    else if (rbus_i.wr)
    begin
      if (rbus_i.addr == `ORX_REG_BANK)
        bank_reg <= rbus_i.wdata[3:0];
      if (rbus_i.addr == `ORX_REG_CFG)
        ext_en_reg <= rbus_i.wdata[0];
      if (rbus_i.addr == `ORX_REG_MADDR)
        maddr_reg <= rbus_i.wdata[11:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !rbus_i.rd)
      rd_data_o <= 16'h0000;
    else
    begin
      case (rbus_i.addr)
        `ORX_REG_ACC:   rd_data_o <= {8'h00, acc_reg};
        `ORX_REG_BANK:  rd_data_o <= {12'h000, bank_reg};
        `ORX_REG_FLAGS: rd_data_o <= {14'h0000, flags_reg};
        `ORX_REG_PTR0:  rd_data_o <= {4'h0, ptr_reg[0]};
        `ORX_REG_PTR1:  rd_data_o <= {4'h0, ptr_reg[1]};
        `ORX_REG_PTR2:  rd_data_o <= {4'h0, ptr_reg[2]};
        `ORX_REG_CFG:   rd_data_o <= {15'h0000, ext_en_reg};
        `ORX_REG_MADDR: rd_data_o <= {4'h0, maddr_reg};
        `ORX_REG_MDATA: rd_data_o <= {8'h00, mem[maddr_reg]};
        default:        rd_data_o <= 16'h0000;
      endcase
    end
  end

  // Checks share the one clock and stay quiet while reset is held
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_quarters;
    state_reg == orx_pkg::ST_Q1 ##1 state_reg == orx_pkg::ST_Q2
      ##1 state_reg == orx_pkg::ST_Q3 ##1 state_reg == orx_pkg::ST_Q4;
  endsequence

  sequence s_q4_of(orx_pkg::orx_class_t c);
    state_reg == orx_pkg::ST_Q4 && cls_reg == c;
  endsequence

  sequence s_busy_cycle;
    busy_o [*4] ##1 !busy_o;
  endsequence

  a_phase_order: assert property (take |=> s_quarters ##1 state_reg == orx_pkg::ST_IDLE) // RULE_13
    else $error("quarter phases out of order");

  a_or_literal: assert property (s_q4_of(orx_pkg::CL_OR_LIT) // RULE_01
    |-> ##1 acc_reg == ($past(acc_reg, 2) | $past(instr_reg[7:0])))
    else $error("literal OR result wrong");

  a_or_file_val: assert property (s_q4_of(orx_pkg::CL_OR_FILE) // RULE_02
    |-> result_reg == (acc_reg | opnd_reg))
    else $error("register OR result wrong");

  a_dest_to_acc: assert property (q4_file && !dest_reg |=> acc_reg == $past(result_reg)) // RULE_03
    else $error("result not placed in accumulator");

  a_dest_to_file: assert property (q4_file && dest_reg // RULE_04
    |=> mem[$past(addr_reg)] == $past(result_reg) && acc_reg == $past(acc_reg))
    else $error("result not written back to file");

  a_access_bank: assert property (state_reg == orx_pkg::ST_Q1 && !instr_reg[`ORX_BIT_BANK] // RULE_05
    && !(ext_en_reg && fa <= `ORX_ILO_MAX)
    |=> addr_reg == {(fa[7] ? `ORX_ACC_HI_BANK : `ORX_ACC_LO_BANK), $past(fa)})
    else $error("access bank address wrong");

  a_bank_select: assert property (state_reg == orx_pkg::ST_Q1 && instr_reg[`ORX_BIT_BANK] // RULE_06 RULE_11
    |=> addr_reg == {$past(bank_reg), $past(fa)})
    else $error("banked address wrong");

  a_indexed_mode: assert property (state_reg == orx_pkg::ST_Q1 && !instr_reg[`ORX_BIT_BANK] // RULE_07
    && ext_en_reg && fa <= `ORX_ILO_MAX |=> addr_reg == $past(ptr_reg[2]) + {4'h0, $past(fa)})
    else $error("indexed offset address wrong");

  a_flag_update: assert property (state_reg == orx_pkg::ST_Q4 // RULE_08
    && (cls_reg == orx_pkg::CL_OR_LIT || q4_file)
    |=> flags_reg == {$past(result_reg[7]), $past(result_reg) == 8'h00})
    else $error("negative or zero flag wrong");

  a_ptr_flags_kept: assert property (state_reg == orx_pkg::ST_Q4 // RULE_08
    && (cls_reg == orx_pkg::CL_PTR_HI || cls_reg == orx_pkg::CL_PTR_LO) && !rbus_i.wr
    |=> $stable(flags_reg) && $stable(acc_reg))
    else $error("pointer load touched flags");

  a_ptr_high: assert property (s_q4_of(orx_pkg::CL_PTR_HI) // RULE_09 RULE_12
    |=> ptr_reg[ptr_sel_reg][11:8] == $past(instr_reg[3:0]) && ptr_pend_reg)
    else $error("pointer high part not loaded");

  a_ptr_low: assert property (s_q4_of(orx_pkg::CL_PTR_LO) // RULE_12
    |=> ptr_reg[$past(ptr_sel_reg)][7:0] == $past(instr_reg[7:0]) && !ptr_pend_reg)
    else $error("pointer low byte not loaded");

  a_move_copy: assert property (s_q4_of(orx_pkg::CL_MOVE) |-> result_reg == opnd_reg) // RULE_10
    else $error("move result differs from operand");

  a_busy_span: assert property (take |=> s_busy_cycle) // RULE_13
    else $error("busy level does not span four quarters");

  a_bad_select: assert property (state_reg == orx_pkg::ST_Q1 && instr_reg[15:6] == `ORX_OP_PTR_FIRST // RULE_09
    && instr_reg[5:4] == `ORX_PTR_SEL_BAD |=> cls_reg == orx_pkg::CL_NOP)
    else $error("pointer selector 3 not refused");

  a_pair_cancel: assert property (state_reg == orx_pkg::ST_Q4 && cls_reg != orx_pkg::CL_PTR_HI // RULE_12
    |=> !ptr_pend_reg)
    else $error("pointer pairing not cancelled");

  a_nop_quiet: assert property (state_reg == orx_pkg::ST_Q4 && cls_reg == orx_pkg::CL_NOP && !rbus_i.wr // RULE_09
    |=> $stable(acc_reg) && $stable(flags_reg)
      && $stable(ptr_reg[0]) && $stable(ptr_reg[1]) && $stable(ptr_reg[2]))
    else $error("refused word changed state");

endmodule // orx_exec

// *** bench/orx_exec_bench.sv ***
// Purpose: Self-checking bench for the OR / move / pointer-load slice
// Assumes: Registers and data memory reached through the plain register port
// Notes:   Data memory is not reset, so every location is written before use
`timescale 1ns/1ps
`include "orx_map.svh"

module or_move_fsr_load_exec_bench;
  logic                mclk_i = 1'b0;
  logic                srst_i = 1'b1;
  orx_pkg::orx_instr_t instr_i = '0;
  orx_pkg::orx_rbus_t  rbus_i = '0;
  logic [15:0]         rd_data_o;
  logic                busy_o;
  logic [7:0]          acc_o;
  logic [1:0]          flags_o;
  logic [15:0]         exp_q[$];
  logic                rd_seen = 1'b0;
  logic [31:0]         rnd = 32'h955a;
  logic [7:0]          acc_m = 8'h00;
  logic [1:0]          flg_m = 2'h0;
  logic [3:0]          bank_m = 4'h0;
  logic [11:0]         ptr_m[3] = '{default: 12'h000};
  logic                ext_m = 1'b0;
  logic [7:0]          mem_m[logic [11:0]];
  int                  n_mismatch = 0;
  int                  tests_run = 0;

  orx_exec dut (.mclk_i(mclk_i), .srst_i(srst_i), .instr_i(instr_i), .rbus_i(rbus_i),
    .rd_data_o(rd_data_o), .busy_o(busy_o), .acc_o(acc_o), .flags_o(flags_o));

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  function automatic logic [7:0] rand8();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[7:0];
  endfunction

  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      n_mismatch++;
    end
  endtask

  // Read data stands one cycle only; it is looked at mid-cycle, away from the edges that move it
  always @(posedge mclk_i)
  begin
    rd_seen <= rbus_i.rd;
  end

  always @(negedge mclk_i)
  begin
    if (!srst_i && rd_seen)
      chk(rd_data_o, exp_q.pop_front(), "read data");
    else if (!srst_i)
      chk(rd_data_o, 16'h0000, "idle read data");
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i) rbus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i) rbus_i <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk_i) rbus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge mclk_i) rbus_i <= '0;
  endtask

  task automatic setm(input logic [11:0] a, input logic [7:0] v);
    mem_m[a] = v;
    wr(`ORX_REG_MADDR, {4'h0, a});
    wr(`ORX_REG_MDATA, {8'h00, v});
  endtask

  task automatic chkm(input logic [11:0] a);
    wr(`ORX_REG_MADDR, {4'h0, a});
    rd(`ORX_REG_MDATA, {8'h00, mem_m[a]});
  endtask

  task automatic chk_core();
    rd(`ORX_REG_ACC, {8'h00, acc_m});
    rd(`ORX_REG_FLAGS, {14'h0000, flg_m});
    @(negedge mclk_i);
    chk({8'h00, acc_o}, {8'h00, acc_m}, "acc port");
    chk({14'h0000, flags_o}, {14'h0000, flg_m}, "flags port");
  endtask

  task automatic chk_ptrs();
    for (int i = 0; i < 3; i++)
      rd(`ORX_REG_PTR0 + i[3:0], {4'h0, ptr_m[i]});
  endtask

  task automatic exec(input logic [15:0] w);
    int n = 0;
    @(posedge mclk_i) instr_i <= '{valid: 1'b1, word: w};
    @(posedge mclk_i) instr_i <= '0;
    #1;
    chk({15'h0000, busy_o}, 16'h0001, "busy after take");
    while (busy_o === 1'b1 && n < 20)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    chk(n[15:0], 16'h0004, "quarter count");
  endtask

  task automatic or_lit(input logic [7:0] k);
    acc_m = acc_m | k;
    flg_m = {acc_m[7], acc_m == 8'h00};
    exec({`ORX_OP_OR_LIT, k});
    chk_core();
  endtask

  task automatic fop(input logic mv, input logic d, input logic a, input logic [7:0] f);
    logic [11:0] ea;
    logic [7:0]  r;
    if (a)
      ea = {bank_m, f};
    else if (ext_m && f <= `ORX_ILO_MAX)
      ea = ptr_m[2] + {4'h0, f};
    else
      ea = (f < 8'h80) ? {`ORX_ACC_LO_BANK, f} : {`ORX_ACC_HI_BANK, f};
    setm(ea, rand8());
    r = mv ? mem_m[ea] : (acc_m | mem_m[ea]);
    flg_m = {r[7], r == 8'h00};
    if (d)
      mem_m[ea] = r;
    else
      acc_m = r;
    exec({mv ? `ORX_OP_MOVE_FILE : `ORX_OP_OR_FILE, d, a, f});
    chk_core();
    chkm(ea);
  endtask

  task automatic ptr_load(input logic [1:0] s, input logic [11:0] k);
    exec({`ORX_OP_PTR_FIRST, s, k[11:8]});
    exec({`ORX_OP_PTR_SECOND, k[7:0]});
    if (s != `ORX_PTR_SEL_BAD)
      ptr_m[s] = k;
    chk_ptrs();
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(i[3:0], 16'h0000);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    rd(4'hf, 16'h0000);
    acc_m = 8'h9a;
    wr(`ORX_REG_ACC, 16'h009a);
    or_lit(8'h35);
    acc_m = 8'h00;
    wr(`ORX_REG_ACC, 16'h0000);
    or_lit(8'h00);
    for (int i = 0; i < 4; i++)
      or_lit(rand8());
    bank_m = 4'h5;
    wr(`ORX_REG_BANK, 16'h0005);
    rd(`ORX_REG_BANK, 16'h0005);
    // Every move/OR, destination and bank combination once
    for (int i = 0; i < 8; i++)
      fop(i[2], i[1], i[0], rand8());
    fop(1'b0, 1'b1, 1'b0, 8'h7f);
    fop(1'b1, 1'b0, 1'b0, 8'h80);
    bank_m = 4'ha;
    wr(`ORX_REG_BANK, 16'h000a);
    fop(1'b1, 1'b1, 1'b1, 8'hff);
    ptr_load(2'h2, 12'h3ab);
    ptr_load(2'h0, 12'hfff);
    ptr_load(2'h1, 12'h001);
    ptr_load(2'h3, 12'h555);
    chk_core();
    ext_m = 1'b1;
    wr(`ORX_REG_CFG, 16'h0001);
    fop(1'b0, 1'b1, 1'b0, 8'h5f);
    fop(1'b0, 1'b0, 1'b0, 8'h60);
    fop(1'b1, 1'b0, 1'b0, 8'h00);
    fop(1'b0, 1'b1, 1'b1, 8'h10);
    // A lone second word must not touch any pointer
    exec({`ORX_OP_PTR_SECOND, 8'h12});
    chk_ptrs();
    // Broken pairing keeps the high part already written
    exec({`ORX_OP_PTR_FIRST, 2'h1, 4'h7});
    ptr_m[1][11:8] = 4'h7;
    or_lit(8'h01);
    exec({`ORX_OP_PTR_SECOND, 8'h99});
    chk_ptrs();
    @(posedge mclk_i) srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    acc_m = 8'h00;
    flg_m = 2'h0;
    ptr_m = '{default: 12'h000};
    chk_core();
    chk_ptrs();
    rd(`ORX_REG_BANK, 16'h0000);
    rd(`ORX_REG_CFG, 16'h0000);
    chkm(12'h40a);
    repeat (3) @(posedge mclk_i);
    tally_and_finish();
  end
endmodule // or_move_fsr_load_exec_bench
